// ---- testbench/periph_model.sv ----
`timescale 1ns/1ns
module periph_model #(
  parameter int NUM_PERIPH = 15
) (
  input wire logic fixed_on, // Fixed functions active
  input wire logic [15:0] pad_out, // Port drive level
  input wire logic [15:0] pad_oe, // Port drive enable
  output logic [NUM_PERIPH-1:0] periph_out, // Remappable outputs
  output logic [NUM_PERIPH-1:0] periph_oe, // Remappable enables
  output logic [15:0] fixed_en, // Fixed function active
  output logic [15:0] fixed_out, // Fixed function data
  output logic [15:0] fixed_oe, // Fixed function enable
  output logic [15:0] pad_in // Resolved pad level
);
  // Alternating data so a routed pin differs from the port latch
  assign periph_out = NUM_PERIPH'(16'h2AAA);
  assign periph_oe = '1;
  assign fixed_en = {16{fixed_on}};
  assign fixed_out = 16'hFFFF;
  assign fixed_oe = 16'hFFFF;
  // Pull-up holds an undriven pad high
  assign pad_in = (pad_oe & pad_out) | ~pad_oe;
endmodule : periph_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
`include "io_port_defines.svh"
module testbench;
  import io_port_pkg::*;
  localparam int NP = 15;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fixed_on, err;
  logic [15:0] paddr, fx_en, fx_out, fx_oe, pad_in, pad_out, pad_oe, pad_analog, p2p;
  logic [31:0] pwdata, prdata, pad_slew, rd;
  logic [NP-1:0] periph_out, periph_oe;
  int num_errors, checked;
  io_port_slew_atomic_remap #(.NUM_PERIPH(NP)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_out(periph_out),
    .periph_oe(periph_oe), .fixed_periph_en(fx_en), .fixed_periph_out(fx_out),
    .fixed_periph_oe(fx_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_analog(pad_analog), .pin_to_periph(p2p), .pad_slew(pad_slew));
  periph_model #(.NUM_PERIPH(NP)) far_u (.fixed_on(fixed_on), .pad_out(pad_out),
    .pad_oe(pad_oe), .periph_out(periph_out), .periph_oe(periph_oe), .fixed_en(fx_en),
    .fixed_out(fx_out), .fixed_oe(fx_oe), .pad_in(pad_in));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Starts right after an edge and leaves one edge after the release
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: no ready", $time);
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Pad outputs trail the register write by one more edge
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task automatic t_reset();
    logic [15:0] osel [15] = '{16'h15B4, 16'h15B8, 16'h15C0, 16'h15C4, 16'h15C8,
      16'h15CC, 16'h15D0, 16'h15D4, 16'h15D8, 16'h15DC, 16'h15E4, 16'h15E8, 16'h15EC,
      16'h15F0, 16'h15F8};
    apb(1'b0, `PORT_BASE_TRIS, 32'h0);
    chk(rd, 32'h0000FFFF);
    apb(1'b0, `PORT_BASE_SLEW_HI, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `PORT_BASE_SLEW_LO, 32'h0);
    chk(rd, 32'h0);
    chk(pad_slew, 32'h0);
    foreach (osel[i]) begin
      apb(1'b0, osel[i], 32'h0);
      chk(rd, 32'h0);
    end
  endtask : t_reset
  task automatic t_slew();
    apb(1'b1, `PORT_BASE_SLEW_HI, 32'h3);
    apb(1'b1, `PORT_BASE_SLEW_LO, 32'h5);
    settle();
    chk(pad_slew, {24'h0, SLEW_FASTEST, SLEW_MEDIUM, SLEW_SLOW, SLEW_SLOWEST});
    @(posedge pclk);
  endtask : t_slew
  task automatic t_atomic();
    apb(1'b1, `PORT_BASE_LAT, 32'h00F0);
    apb(1'b1, `PORT_BASE_LAT + 16'h8, 32'h000F);
    apb(1'b0, `PORT_BASE_LAT, 32'h0);
    chk(rd, 32'h00FF);
    apb(1'b1, `PORT_BASE_LAT + 16'h4, 32'h0011);
    apb(1'b0, `PORT_BASE_LAT, 32'h0);
    chk(rd, 32'h00EE);
    apb(1'b1, `PORT_BASE_LAT + 16'hC, 32'h0101);
    apb(1'b0, `PORT_BASE_LAT, 32'h0);
    chk(rd, 32'h01EF);
    apb(1'b0, `PORT_BASE_LAT + 16'h4, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `PORT_BASE_TRIS + 16'h4, 32'hFFFF);
    apb(1'b0, `PORT_BASE_TRIS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_atomic
  task automatic t_remap();
    apb(1'b1, 16'h15B4, 32'h1);
    apb(1'b1, 16'h15B8, 32'hFFFFFFF3);
    apb(1'b0, 16'h15B8, 32'h0);
    chk(rd, 32'h3);
    settle();
    chk({pad_out, pad_oe}, {16'h01EC, 16'hFFFF});
    @(posedge pclk);
    fixed_on <= 1'b1;
    settle();
    chk(pad_out, 16'hFFFC);
    @(posedge pclk);
    fixed_on <= 1'b0;
    @(posedge pclk);
    apb(1'b1, `PORT_BASE_ANSEL + 16'h8, 32'h1);
    settle();
    chk(pad_analog, 16'h0001);
    chk(p2p, 16'h01EC);
    @(posedge pclk);
    apb(1'b1, `PORT_BASE_ANSEL + 16'h4, 32'h1);
  endtask : t_remap
  task automatic t_lock();
    apb(1'b1, `REMAP_LOCK_ADDR, 32'h1);
    apb(1'b1, `REMAP_LOCK_ADDR, 32'h0);
    apb(1'b1, 16'h15B4, 32'h2);
    apb(1'b0, 16'h15B4, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `REMAP_KEY_ADDR, `REMAP_KEY_VALUE);
    apb(1'b1, `REMAP_LOCK_ADDR, 32'h0);
    apb(1'b1, 16'h15B4, 32'h0);
    apb(1'b0, 16'h15B4, 32'h0);
    chk(rd, 32'h0);
    settle();
    chk(pad_out, 16'h01ED);
    @(posedge pclk);
    apb(1'b0, 16'h1FF0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_lock
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    fixed_on = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_slew();
    t_atomic();
    t_remap();
    t_lock();
    wrap_up();
  end
endmodule : testbench

// ---- verilog/io_port_defines.svh ----
`ifndef IO_PORT_DEFINES_SVH
`define IO_PORT_DEFINES_SVH

// Port register block (coined offsets), each base with three aliases at +4/+8/+C
`define PORT_BASE_LAT 16'h1000
`define PORT_BASE_TRIS 16'h1010
`define PORT_BASE_SLEW_HI 16'h1020
`define PORT_BASE_SLEW_LO 16'h1030
`define PORT_BASE_ANSEL 16'h1040
`define PORT_PIN_STATE 16'h1050
`define ALIAS_CLR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INV 2'h3
// Remap lock: writing 1 locks; write key then 0 to unlock
`define REMAP_LOCK_ADDR 16'h1060
`define REMAP_KEY_ADDR 16'h1064
`define REMAP_KEY_VALUE 32'h5A5AA5A5
// Output select registers
`define OSEL_FIRST 16'h15B4
`define OSEL_LAST 16'h15F8
`define PIN_C13_OSEL_ADDR 16'h15B4
`define PIN_C14_OSEL_ADDR 16'h15B8
`define PIN_D0_OSEL_ADDR 16'h15C0
`define PIN_D1_OSEL_ADDR 16'h15C4
`define PIN_D2_OSEL_ADDR 16'h15C8
`define PIN_D3_OSEL_ADDR 16'h15CC
`define PIN_D4_OSEL_ADDR 16'h15D0
`define PIN_D5_OSEL_ADDR 16'h15D4
`define PIN_D6_OSEL_ADDR 16'h15D8
`define PIN_D7_OSEL_ADDR 16'h15DC
`define PIN_D9_OSEL_ADDR 16'h15E4
`define PIN_D10_OSEL_ADDR 16'h15E8
`define PIN_D11_OSEL_ADDR 16'h15EC
`define PIN_D12_OSEL_ADDR 16'h15F0
`define PIN_D14_OSEL_ADDR 16'h15F8
`define OSEL_CODE_MSB 3
`define OSEL_RESET 4'h0
`define TRIS_RESET 16'hFFFF
`define PORT_RESET 16'h0000

`endif

// ---- verilog/io_port_pkg.sv ----
package io_port_pkg;
  typedef enum logic [1:0] {
    SLEW_FASTEST = 2'h0,
    SLEW_MEDIUM = 2'h1,
    SLEW_SLOW = 2'h2,
    SLEW_SLOWEST = 2'h3
  } slew_rate_type;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_WAIT = 3'b010,
    ACC_DONE = 3'b100
  } acc_state_type;
endpackage : io_port_pkg

// ---- verilog/io_port_slew_atomic_remap.sv ----
// Functional notes
// - Each pin's edge rate comes from same-position bits of high and low slew regs.
// - High/low 1/1 slowest, 1/0 slow, 0/1 medium; slew control enabled.
// - Both bits 0: slew control off, fastest edge rate.
// - Reset clears all slew bits, so every pin starts fastest.
// - Each port register has clear, set and invert write aliases, atomic.
// - Alias writes change only bits written as 1.
// - Alias reads return undefined data; software reads the base register.
// - Any remappable output may be routed independently to any remappable pin.
// - Remappable functions: serial, timer clocks, capture, compare, change, refclk.
// - I2C and analog-input modules stay on fixed pins, never remapped.
// - Non-remappable peripherals reach their default pin when active, unless analog or a remapped output owns the pin.
// - Active remapped peripheral beats port I/O and all other digital functions.
// - Analog function on a pin always beats a remapped peripheral.
// - A lock blocks accidental changes to the pin mapping.
// - Output select: 32-bit reg, 4-bit code in bits 3:0, rest zero, reset zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "io_port_defines.svh"
module io_port_slew_atomic_remap
  import io_port_pkg::*;
#(
  parameter int NUM_PERIPH = 15
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [15:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [NUM_PERIPH-1:0] periph_out, // Remappable peripheral outputs
  input wire logic [NUM_PERIPH-1:0] periph_oe, // Remappable peripheral enables
  input wire logic [15:0] fixed_periph_en, // Fixed peripheral active per pin
  input wire logic [15:0] fixed_periph_out, // Fixed peripheral data per pin
  input wire logic [15:0] fixed_periph_oe, // Fixed peripheral enable per pin
  input wire logic [15:0] pad_in, // Pad input level
  output logic [15:0] pad_out, // Pad output level
  output logic [15:0] pad_oe, // Pad output enable
  output logic [15:0] pad_analog, // Pad switched to analog
  output logic [15:0] pin_to_periph, // Pad input fanned to peripheral input muxes
  output logic [31:0] pad_slew // 2 bits per pin edge rate
);
  localparam int NPIN = 16;
  // Pin index of each select register; gaps in the map stay unmapped
  localparam logic [15:0] OSEL_ADDR [15] = '{
    `PIN_C13_OSEL_ADDR,
    `PIN_C14_OSEL_ADDR,
    `PIN_D0_OSEL_ADDR,
    `PIN_D1_OSEL_ADDR,
    `PIN_D2_OSEL_ADDR,
    `PIN_D3_OSEL_ADDR,
    `PIN_D4_OSEL_ADDR,
    `PIN_D5_OSEL_ADDR,
    `PIN_D6_OSEL_ADDR,
    `PIN_D7_OSEL_ADDR,
    `PIN_D9_OSEL_ADDR,
    `PIN_D10_OSEL_ADDR,
    `PIN_D11_OSEL_ADDR,
    `PIN_D12_OSEL_ADDR,
    `PIN_D14_OSEL_ADDR
  };

  logic [15:0] lat_q, tris_q, slew_hi_q, slew_lo_q, ansel_q;
  logic [3:0] osel_q [NPIN];
  logic remap_lock_q, key_ok_q;
  acc_state_type state_q;
  logic wr_access, rd_access;

  function automatic logic [15:0] alias_apply(input logic [15:0] cur, input logic [1:0] op,
      input logic [15:0] val);
    unique case (op)
      2'h0: alias_apply = val;
      `ALIAS_CLR: alias_apply = cur & ~val;
      `ALIAS_SET: alias_apply = cur | val;
      default: alias_apply = cur ^ val;
    endcase
  endfunction : alias_apply

  function automatic logic hit(input logic [15:0] base, input logic [15:0] a);
    hit = (a[15:4] == base[15:4]) && (a[1:0] == 2'h0);
  endfunction : hit

  function automatic int osel_index(input logic [15:0] a);
    osel_index = -1;
    for (int i = 0; i < 15; i++) begin
      if (a == OSEL_ADDR[i]) begin
        osel_index = i;
      end
    end
  endfunction : osel_index

  // Zero wait states: access phase answers in its first cycle
  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;

  // Access tracking, one-hot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ACC_IDLE;
    end else begin
      unique case (state_q)
        ACC_IDLE: state_q <= (psel && !penable) ? ACC_WAIT : ACC_IDLE;
        ACC_WAIT: state_q <= ACC_DONE;
        ACC_DONE: state_q <= (psel && !penable) ? ACC_WAIT : ACC_IDLE;
        default: state_q <= ACC_IDLE;
      endcase
    end
  end

  function automatic logic mapped(input logic [15:0] a);
    mapped = hit(`PORT_BASE_LAT, a) || hit(`PORT_BASE_TRIS, a) ||
      hit(`PORT_BASE_SLEW_HI, a) || hit(`PORT_BASE_SLEW_LO, a) ||
      hit(`PORT_BASE_ANSEL, a) || a == `PORT_PIN_STATE || a == `REMAP_LOCK_ADDR ||
      a == `REMAP_KEY_ADDR || osel_index(a) >= 0;
  endfunction : mapped

  assign pslverr = psel && penable && !mapped(paddr);

  // Port registers: base writes and atomic aliases finish in the one write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= `PORT_RESET;
      tris_q <= `TRIS_RESET;
      slew_hi_q <= `PORT_RESET;
      slew_lo_q <= `PORT_RESET;
      ansel_q <= `PORT_RESET;
    end else if (wr_access) begin
      if (hit(`PORT_BASE_LAT, paddr)) begin
        lat_q <= alias_apply(lat_q, paddr[3:2], pwdata[15:0]);
      end
      if (hit(`PORT_BASE_TRIS, paddr)) begin
        tris_q <= alias_apply(tris_q, paddr[3:2], pwdata[15:0]);
      end
      if (hit(`PORT_BASE_SLEW_HI, paddr)) begin
        slew_hi_q <= alias_apply(slew_hi_q, paddr[3:2], pwdata[15:0]);
      end
      if (hit(`PORT_BASE_SLEW_LO, paddr)) begin
        slew_lo_q <= alias_apply(slew_lo_q, paddr[3:2], pwdata[15:0]);
      end
      if (hit(`PORT_BASE_ANSEL, paddr)) begin
        ansel_q <= alias_apply(ansel_q, paddr[3:2], pwdata[15:0]);
      end
    end
  end

  // Mapping lock: unlock needs the key written first, so one stray write cannot open it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remap_lock_q <= 1'b0;
      key_ok_q <= 1'b0;
    end else if (wr_access) begin
      key_ok_q <= (paddr == `REMAP_KEY_ADDR) && (pwdata == `REMAP_KEY_VALUE);
      if (paddr == `REMAP_LOCK_ADDR) begin
        if (pwdata[0]) begin
          remap_lock_q <= 1'b1;
        end else if (key_ok_q) begin
          remap_lock_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPIN; i++) begin
        osel_q[i] <= `OSEL_RESET;
      end
    end else if (wr_access && !remap_lock_q) begin
      for (int i = 0; i < 15; i++) begin
        if (paddr == OSEL_ADDR[i]) begin
          osel_q[i] <= pwdata[`OSEL_CODE_MSB:0];
        end
      end
    end
  end

  // Read mux; aliases read zero, which software must not rely on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (paddr[3:2] == 2'h0) begin
        if (hit(`PORT_BASE_LAT, paddr)) prdata <= {16'h0, lat_q};
        if (hit(`PORT_BASE_TRIS, paddr)) prdata <= {16'h0, tris_q};
        if (hit(`PORT_BASE_SLEW_HI, paddr)) prdata <= {16'h0, slew_hi_q};
        if (hit(`PORT_BASE_SLEW_LO, paddr)) prdata <= {16'h0, slew_lo_q};
        if (hit(`PORT_BASE_ANSEL, paddr)) prdata <= {16'h0, ansel_q};
      end
      if (paddr == `PORT_PIN_STATE) prdata <= {16'h0, pad_in};
      if (paddr == `REMAP_LOCK_ADDR) prdata <= {31'h0, remap_lock_q};
      for (int i = 0; i < 15; i++) begin
        if (paddr == OSEL_ADDR[i]) prdata <= {28'h0, osel_q[i]};
      end
    end
  end

  // Slew: high bit is MSB of the per-pin code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_slew <= 32'h0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        pad_slew[2*p +: 2] <= {slew_hi_q[p], slew_lo_q[p]};
      end
    end
  end

  // Pin ownership: analog, then remapped, then fixed peripheral, then port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 16'h0;
      pad_oe <= 16'h0;
      pad_analog <= 16'h0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        pad_analog[p] <= ansel_q[p];
        if (ansel_q[p]) begin
          pad_out[p] <= 1'b0;
          pad_oe[p] <= 1'b0;
        end else if (p < 15 && osel_q[p] != 4'h0
            && osel_q[p] <= 4'(NUM_PERIPH)) begin
          pad_out[p] <= periph_out[osel_q[p] - 4'h1];
          pad_oe[p] <= periph_oe[osel_q[p] - 4'h1];
        end else if (fixed_periph_en[p]) begin
          pad_out[p] <= fixed_periph_out[p];
          pad_oe[p] <= fixed_periph_oe[p];
        end else begin
          pad_out[p] <= lat_q[p];
          pad_oe[p] <= !tris_q[p];
        end
      end
    end
  end

  // Digital input seen by peripherals is blanked on analog pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_to_periph <= 16'h0;
    end else begin
      pin_to_periph <= pad_in & ~ansel_q;
    end
  end

  sequence s_read_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_write_setup;
    psel && !penable && pwrite;
  endsequence
  sequence s_set_lat;
    wr_access && paddr == (`PORT_BASE_LAT | 16'h8);
  endsequence

  a_slew_reset_fast: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pad_slew == 32'h0)
    else $error("slew not fastest");

  a_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> tris_q == `TRIS_RESET && osel_q[0] == `OSEL_RESET)
    else $error("reset defaults wrong");

  a_slew_follows: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pad_slew[1:0] == {$past(slew_hi_q[0]), $past(slew_lo_q[0])})
    else $error("slew code mismatch");

  a_slew_top_pin: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pad_slew[31:30] == {$past(slew_hi_q[15]), $past(slew_lo_q[15])})
    else $error("top pin slew mismatch");

  a_slew_slowest: assert property (@(posedge pclk) disable iff (!presetn)
    slew_hi_q[0] && slew_lo_q[0] |=> pad_slew[1:0] == SLEW_SLOWEST)
    else $error("slowest code wrong");

  a_slew_slow: assert property (@(posedge pclk) disable iff (!presetn)
    slew_hi_q[1] && !slew_lo_q[1] |=> pad_slew[3:2] == SLEW_SLOW)
    else $error("slow code wrong");

  a_slew_medium: assert property (@(posedge pclk) disable iff (!presetn)
    !slew_hi_q[2] && slew_lo_q[2] |=> pad_slew[5:4] == SLEW_MEDIUM)
    else $error("medium code wrong");

  a_slew_fast_off: assert property (@(posedge pclk) disable iff (!presetn)
    !slew_hi_q[3] && !slew_lo_q[3] |=> pad_slew[7:6] == SLEW_FASTEST)
    else $error("fastest code wrong");

  a_base_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == `PORT_BASE_LAT |=> lat_q == $past(pwdata[15:0]))
    else $error("base write wrong");

  a_clr_alias: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == (`PORT_BASE_LAT | 16'h4) |=> lat_q == ($past(lat_q) & ~$past(pwdata[15:0])))
    else $error("clear alias wrong");

  a_set_alias: assert property (@(posedge pclk) disable iff (!presetn)
    s_set_lat |=> lat_q == ($past(lat_q) | $past(pwdata[15:0])))
    else $error("set alias wrong");

  a_inv_alias: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == (`PORT_BASE_TRIS | 16'hC) |=> tris_q == ($past(tris_q) ^ $past(pwdata[15:0])))
    else $error("invert alias wrong");

  a_clr_tris: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == (`PORT_BASE_TRIS | 16'h4) |=> tris_q == ($past(tris_q) & ~$past(pwdata[15:0])))
    else $error("tris clear wrong");

  a_inv_lat: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == (`PORT_BASE_LAT | 16'hC) |=> lat_q == ($past(lat_q) ^ $past(pwdata[15:0])))
    else $error("latch invert wrong");

  a_lat_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && hit(`PORT_BASE_LAT, paddr)) |=> $stable(lat_q))
    else $error("latch changed without write");

  a_set_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_setup ##1 s_set_lat |-> state_q == ACC_WAIT
    ##1 lat_q == ($past(lat_q) | $past(pwdata[15:0])))
    else $error("set alias split");

  a_read_alias: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup ##1 (psel && penable && paddr == (`PORT_BASE_LAT | 16'h4)) |-> prdata == 32'h0)
    else $error("alias read not zero");

  a_osel_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_setup ##0 (paddr == `PIN_C13_OSEL_ADDR) |=> prdata[31:4] == 28'h0)
    else $error("select upper bits set");

  a_osel_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && !remap_lock_q && paddr == `PIN_C14_OSEL_ADDR |=> osel_q[1] == $past(pwdata[3:0]))
    else $error("select write lost");

  a_lock_sets: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == `REMAP_LOCK_ADDR && pwdata[0] |=> remap_lock_q)
    else $error("lock not set");

  a_unlock_key: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == `REMAP_LOCK_ADDR && !key_ok_q && remap_lock_q |=> remap_lock_q)
    else $error("unlocked without key");

  a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
    remap_lock_q && wr_access |=> osel_q[0] == $past(osel_q[0]))
    else $error("locked map changed");

  a_lock_last: assert property (@(posedge pclk) disable iff (!presetn)
    remap_lock_q && wr_access |=> osel_q[14] == $past(osel_q[14]))
    else $error("locked last select changed");

  a_analog_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ansel_q[0] |=> !pad_oe[0])
    else $error("analog pin driven");

  a_analog_blank: assert property (@(posedge pclk) disable iff (!presetn)
    ansel_q[0] |=> !pin_to_periph[0])
    else $error("analog pin seen as digital");

  a_analog_flag: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pad_analog == $past(ansel_q))
    else $error("analog flag wrong");

  a_remap_wins: assert property (@(posedge pclk) disable iff (!presetn)
    !ansel_q[0] && osel_q[0] == 4'h1 |=> pad_out[0] == $past(periph_out[0]))
    else $error("remap lost priority");

  a_remap_oe: assert property (@(posedge pclk) disable iff (!presetn)
    !ansel_q[1] && osel_q[1] == 4'h3 |=> pad_oe[1] == $past(periph_oe[2]))
    else $error("remap enable lost");

  a_remap_over_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    !ansel_q[0] && osel_q[0] == 4'h1 && fixed_periph_en[0] |=> pad_oe[0] == $past(periph_oe[0]))
    else $error("fixed beat remap");

  a_fixed_pin: assert property (@(posedge pclk) disable iff (!presetn)
    !ansel_q[15] && fixed_periph_en[15] |=> pad_out[15] == $past(fixed_periph_out[15]))
    else $error("fixed function lost");

  a_port_latch: assert property (@(posedge pclk) disable iff (!presetn)
    !ansel_q[5] && osel_q[5] == 4'h0 && !fixed_periph_en[5] |=> pad_out[5] == $past(lat_q[5]))
    else $error("port latch lost");

  a_code_zero_port: assert property (@(posedge pclk) disable iff (!presetn)
    !ansel_q[1] && osel_q[1] == 4'h0 && !fixed_periph_en[1] |=> pad_oe[1] == !$past(tris_q[1]))
    else $error("port control lost");
endmodule : io_port_slew_atomic_remap
